// ---- logic/adc_shutdown_pkg.sv ----
// constants, field layout and state type for the converter shutdown control
// assumes a host serial port driving chip select, shift clock and config input
//
// Notes on behaviour
// - a config word whose word-length field reads high bit 0, low bit 1 requests shutdown.
// - after shutdown the next conversion request powers up and converts at once, no wake delay.
// - a request is a falling chip select, or the first shift clock of a new 16-clock frame while select stays low.
// - once requested, power-down starts at the falling edge of the tenth shift clock.
// - entering shutdown runs one dummy conversion, then stays powered down (sleep, not idle) until the next request.
// - shift clocks still arriving after the dummy conversion count as a request and wake it.
// - an all-high config word selects single-ended top channel, unipolar, msb first, 16 bits.

package adc_shutdown_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned SYS_PERIOD_NS = 10;
  localparam int unsigned CONV_TIME_NS = 130;
  localparam logic [4:0] CONV_CYCLES =
    5'((CONV_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

  // ------------------------------------------------------------
  // shift clock framing
  // ------------------------------------------------------------
  localparam logic [4:0] CFG_BITS = 5'h08;
  localparam logic [4:0] SCLK_TENTH = 5'h0a;
  localparam logic [4:0] FRAME_SCLKS = 5'h10;

  // ------------------------------------------------------------
  // config word layout, first bit shifted in lands at the top
  // ------------------------------------------------------------
  localparam int unsigned CFG_SGL_BIT = 7;
  localparam int unsigned CFG_CH_HI = 6;
  localparam int unsigned CFG_CH_LO = 4;
  localparam int unsigned CFG_UNI_BIT = 3;
  localparam int unsigned CFG_MSBF_BIT = 2;
  localparam int unsigned CFG_WL_HI_BIT = 1;
  localparam int unsigned CFG_WL_LO_BIT = 0;
  localparam logic [7:0] CFG_RESET = 8'hff;

  // word-length codes as {word_len_bit_hi, word_len_bit_lo}
  localparam logic [1:0] WL_8 = 2'h0;
  localparam logic [1:0] WL_SHUTDOWN = 2'h1;
  localparam logic [1:0] WL_12 = 2'h2;
  localparam logic [1:0] WL_16 = 2'h3;
  localparam logic [4:0] WORD_BITS_8 = 5'h08;
  localparam logic [4:0] WORD_BITS_12 = 5'h0c;
  localparam logic [4:0] WORD_BITS_16 = 5'h10;
  localparam logic [4:0] WORD_BITS_NONE = 5'h00;

  typedef enum logic [1:0] {st_idle, st_convert, st_dummy, st_sleep} sys_state_t;

  // word length in bits for a word-length code
  function automatic logic [4:0] word_bits_of(input logic [1:0] code);
    case (code)
      WL_8: word_bits_of = WORD_BITS_8;
      WL_12: word_bits_of = WORD_BITS_12;
      WL_16: word_bits_of = WORD_BITS_16;
      default: word_bits_of = WORD_BITS_NONE;
    endcase
  endfunction

endpackage

// ---- logic/sclk_frame_capture.sv ----
// shift-clock side of the shutdown control: counts clocks, shifts the config word
// assumes chip select high clears the frame; the shift clock may stop between frames
`timescale 1ns/1ns

module sclk_frame_capture (
  // link pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  // level from the system side
  input wire logic i_asleep,
  // levels to the system side
  output logic [7:0] o_cfg,
  output logic o_tenth,
  output logic o_restart,
  output logic o_wake
);

  typedef struct packed {
    logic [4:0] count;
    logic [7:0] cfg;
    logic restart;
    logic asleep_s1;
    logic asleep_s2;
    logic wake;
  } link_state_t;

  link_state_t st;
  link_state_t next_st;
  logic tenth;

  // ------------------------------------------------------------
  // rising-edge frame logic
  // ------------------------------------------------------------
  // every signal leaving here is a level, so a select-high clear never fakes an event
  always_comb begin
    next_st = st;
    next_st.asleep_s1 = i_asleep;
    next_st.asleep_s2 = st.asleep_s1;
    if (st.count == adc_shutdown_pkg::FRAME_SCLKS) begin
      next_st.count = 5'h01;
      next_st.restart = 1'b1;
    end else begin
      next_st.count = st.count + 5'h01;
      if (next_st.count == adc_shutdown_pkg::CFG_BITS) begin
        next_st.restart = 1'b0;
      end
    end
    if (next_st.count <= adc_shutdown_pkg::CFG_BITS) begin
      next_st.cfg = {st.cfg[6:0], i_din};
    end
    // a clock seen while asleep is a wake request; first two edges only fill the sync
    next_st.wake = st.asleep_s2;
  end

  // cfg is left alone on select high, so a word closed by select rising is still read
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      st.count <= 5'h00;
      st.restart <= 1'b0;
      st.asleep_s1 <= 1'b0;
      st.asleep_s2 <= 1'b0;
      st.wake <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // falling edge of the tenth clock
  // ------------------------------------------------------------
  // not cleared by select: a host raising select just after the tenth clock
  // leaves too short a pulse for the system side; the level drops at the
  // first falling edge of the next frame, which must start a few system cycles later
  always_ff @(negedge i_sclk) begin
    if (st.count == adc_shutdown_pkg::SCLK_TENTH) begin
      tenth <= 1'b1;
    end else if (st.count < adc_shutdown_pkg::SCLK_TENTH) begin
      tenth <= 1'b0;
    end
  end

  assign o_cfg = st.cfg;
  assign o_tenth = tenth;
  assign o_restart = st.restart;
  assign o_wake = st.wake;

endmodule // sclk_frame_capture

// ---- logic/adc_power_shutdown_control.sv ----
// power-shutdown control of a serial successive-approximation converter
// assumes i_sys_clk is the conversion clock; link pins are asynchronous to it
`timescale 1ns/1ns

module adc_power_shutdown_control (
  // system clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // serial link
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  // power and conversion status
  output logic o_power_down,
  output logic o_converter_on,
  output logic o_convert_busy,
  output logic o_dummy_conv,
  // decoded configuration
  output logic o_single_ended,
  output logic [2:0] o_channel,
  output logic o_unipolar,
  output logic o_msb_first,
  output logic [4:0] o_word_bits
);

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic tenth_s1;
    logic tenth_s2;
    logic tenth_d;
    logic restart_s1;
    logic restart_s2;
    logic restart_d;
    logic wake_s1;
    logic wake_s2;
    adc_shutdown_pkg::sys_state_t state;
    logic [4:0] timer;
    logic asleep;
    logic power_down;
    logic conv_on;
    logic busy;
    logic dummy;
    logic single_ended;
    logic [2:0] channel;
    logic unipolar;
    logic msb_first;
    logic [4:0] word_bits;
  } sys_reg_t;

  sys_reg_t st;
  sys_reg_t next_st;
  logic [7:0] link_cfg;
  logic link_tenth;
  logic link_restart;
  logic link_wake;
  logic cs_fall;
  logic tenth_rise;
  logic restart_rise;
  logic req;
  logic shut_req;

  // ------------------------------------------------------------
  // link-clock side
  // ------------------------------------------------------------
  sclk_frame_capture u_link (
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_din(i_din),
    .i_asleep(st.asleep),
    .o_cfg(link_cfg),
    .o_tenth(link_tenth),
    .o_restart(link_restart),
    .o_wake(link_wake)
  );

  // ------------------------------------------------------------
  // events seen after synchronising
  // ------------------------------------------------------------
  assign cs_fall = st.cs_d & ~st.cs_s2;
  assign tenth_rise = st.tenth_s2 & ~st.tenth_d;
  assign restart_rise = st.restart_s2 & ~st.restart_d & ~st.cs_s2;
  assign req = cs_fall | restart_rise;
  // cfg is stable for several shift clocks before the tenth level reaches us
  assign shut_req = tenth_rise &&
    ({link_cfg[adc_shutdown_pkg::CFG_WL_HI_BIT], link_cfg[adc_shutdown_pkg::CFG_WL_LO_BIT]}
     == adc_shutdown_pkg::WL_SHUTDOWN);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.cs_s1 = i_cs_n;
    next_st.cs_s2 = st.cs_s1;
    next_st.cs_d = st.cs_s2;
    next_st.tenth_s1 = link_tenth;
    next_st.tenth_s2 = st.tenth_s1;
    next_st.tenth_d = st.tenth_s2;
    next_st.restart_s1 = link_restart;
    next_st.restart_s2 = st.restart_s1;
    next_st.restart_d = st.restart_s2;
    next_st.wake_s1 = link_wake;
    next_st.wake_s2 = st.wake_s1;
    // config other than a shutdown word takes effect once the tenth clock shows it was fully shifted
    if (tenth_rise && !shut_req) begin
      next_st.single_ended = link_cfg[adc_shutdown_pkg::CFG_SGL_BIT];
      next_st.channel = link_cfg[adc_shutdown_pkg::CFG_CH_HI:adc_shutdown_pkg::CFG_CH_LO];
      next_st.unipolar = link_cfg[adc_shutdown_pkg::CFG_UNI_BIT];
      next_st.msb_first = link_cfg[adc_shutdown_pkg::CFG_MSBF_BIT];
      next_st.word_bits = adc_shutdown_pkg::word_bits_of(
        {link_cfg[adc_shutdown_pkg::CFG_WL_HI_BIT], link_cfg[adc_shutdown_pkg::CFG_WL_LO_BIT]});
    end
    case (st.state)
      adc_shutdown_pkg::st_idle: begin
        if (shut_req) begin
          next_st.state = adc_shutdown_pkg::st_dummy;
          next_st.timer = adc_shutdown_pkg::CONV_CYCLES - 5'h01;
        end else if (req) begin
          next_st.state = adc_shutdown_pkg::st_convert;
          next_st.timer = adc_shutdown_pkg::CONV_CYCLES - 5'h01;
        end
      end
      adc_shutdown_pkg::st_convert: begin
        if (shut_req) begin
          next_st.state = adc_shutdown_pkg::st_dummy;
          next_st.timer = adc_shutdown_pkg::CONV_CYCLES - 5'h01;
        end else if (req) begin
          next_st.timer = adc_shutdown_pkg::CONV_CYCLES - 5'h01;
        end else if (st.timer == 5'h00) begin
          next_st.state = adc_shutdown_pkg::st_idle;
        end else begin
          next_st.timer = st.timer - 5'h01;
        end
      end
      adc_shutdown_pkg::st_dummy: begin
        // requests during the dummy run are dropped; the host should not send any
        if (st.timer == 5'h00) begin
          next_st.state = adc_shutdown_pkg::st_sleep;
        end else begin
          next_st.timer = st.timer - 5'h01;
        end
      end
      adc_shutdown_pkg::st_sleep: begin
        // wake straight into a conversion, no settling wait
        if (req || st.wake_s2) begin
          next_st.state = adc_shutdown_pkg::st_convert;
          next_st.timer = adc_shutdown_pkg::CONV_CYCLES - 5'h01;
        end
      end
      default: begin
        next_st.state = adc_shutdown_pkg::st_idle;
      end
    endcase
    // status flops follow the next state so outputs are registered
    next_st.asleep = (next_st.state == adc_shutdown_pkg::st_sleep);
    next_st.power_down = (next_st.state == adc_shutdown_pkg::st_sleep) ||
      (next_st.state == adc_shutdown_pkg::st_dummy);
    next_st.conv_on = (next_st.state != adc_shutdown_pkg::st_sleep);
    next_st.busy = (next_st.state == adc_shutdown_pkg::st_convert);
    next_st.dummy = (next_st.state == adc_shutdown_pkg::st_dummy);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      st <= '0;
      st.cs_s1 <= 1'b1;
      st.cs_s2 <= 1'b1;
      st.cs_d <= 1'b1;
      st.state <= adc_shutdown_pkg::st_idle;
      st.conv_on <= 1'b1;
      st.single_ended <= adc_shutdown_pkg::CFG_RESET[adc_shutdown_pkg::CFG_SGL_BIT];
      st.channel <= adc_shutdown_pkg::CFG_RESET[adc_shutdown_pkg::CFG_CH_HI:adc_shutdown_pkg::CFG_CH_LO];
      st.unipolar <= adc_shutdown_pkg::CFG_RESET[adc_shutdown_pkg::CFG_UNI_BIT];
      st.msb_first <= adc_shutdown_pkg::CFG_RESET[adc_shutdown_pkg::CFG_MSBF_BIT];
      st.word_bits <= adc_shutdown_pkg::WORD_BITS_16;
    end else begin
      st <= next_st;
    end
  end

  assign o_power_down = st.power_down;
  assign o_converter_on = st.conv_on;
  assign o_convert_busy = st.busy;
  assign o_dummy_conv = st.dummy;
  assign o_single_ended = st.single_ended;
  assign o_channel = st.channel;
  assign o_unipolar = st.unipolar;
  assign o_msb_first = st.msb_first;
  assign o_word_bits = st.word_bits;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  property p_shut_code;
    shut_req && (st.state == adc_shutdown_pkg::st_idle ||
      st.state == adc_shutdown_pkg::st_convert) |=> o_dummy_conv && !o_convert_busy;
  endproperty
  a_shut_code: assert property (p_shut_code) else $error("shutdown code not honoured");

  property p_wake_now;
    st.state == adc_shutdown_pkg::st_sleep && (req || st.wake_s2)
      |=> o_convert_busy && o_converter_on && !o_power_down;
  endproperty
  a_wake_now: assert property (p_wake_now) else $error("no immediate conversion on wake");

  property p_cs_request;
    cs_fall && st.state == adc_shutdown_pkg::st_idle && !shut_req |=> o_convert_busy;
  endproperty
  a_cs_request: assert property (p_cs_request) else $error("chip select fall not taken");

  property p_tenth_power;
    $rose(o_power_down) |-> $past(shut_req);
  endproperty
  a_tenth_power: assert property (p_tenth_power) else $error("power down without request");

  property p_dummy_len;
    $rose(o_dummy_conv) |-> ##13 (!o_dummy_conv && o_power_down && !o_converter_on);
  endproperty
  a_dummy_len: assert property (p_dummy_len) else $error("dummy conversion length wrong");

  property p_late_clocks;
    st.state == adc_shutdown_pkg::st_sleep && st.wake_s2 |=> !o_power_down;
  endproperty
  a_late_clocks: assert property (p_late_clocks) else $error("late clocks did not wake");

  property p_all_high;
    tenth_rise && link_cfg == adc_shutdown_pkg::CFG_RESET |=> o_word_bits == 5'h10 &&
      o_channel == 3'h7 && o_single_ended && o_unipolar && o_msb_first;
  endproperty
  a_all_high: assert property (p_all_high) else $error("all-high word decoded wrong");

  property p_off_quiet;
    o_power_down && !o_dummy_conv |-> !o_convert_busy && !o_converter_on;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("converter active while off");

  c_enter_sleep: cover property ($rose(st.asleep));
  c_wake_late: cover property (st.asleep && st.wake_s2 ##1 o_convert_busy);
  c_wake_cs: cover property (st.asleep && cs_fall ##1 o_convert_busy);
  c_restart: cover property (restart_rise ##1 o_convert_busy);

endmodule // adc_power_shutdown_control

// ---- dv/host_serial_port.sv ----
// host serial port model: drives chip select, shift clock and config input
// assumes the bench calls send_frame from one process at a time
`timescale 1ns/1ns

module host_serial_port (
  // link pins
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din
);
  // ------------------------------------------------------------
  // idle levels
  // ------------------------------------------------------------
  // clock parked low between frames, so no stray edges reach the device
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b1;
  end

  // ------------------------------------------------------------
  // one frame, msb of the config word first
  // ------------------------------------------------------------
  // a slow half period lets clocks outlast the dummy conversion
  task automatic send_frame(input logic [7:0] cfg, input int nclk, input int half,
                            input bit hold);
    o_cs_n <= 1'b0;
    #(half);
    for (int i = 0; i < nclk; i++) begin
      o_din <= (i < 8) ? cfg[7 - i] : ~o_din;
      #(half);
      o_sclk <= 1'b1;
      #(half);
      o_sclk <= 1'b0;
    end
    if (!hold) begin
      #(half);
      o_cs_n <= 1'b1;
      o_din <= ~o_din; // released data never keeps its last value
      #40;
    end
  endtask
endmodule // host_serial_port

// ---- dv/adc_power_shutdown_control_test.sv ----
// self-checking bench for the converter shutdown control
// assumes the host model in host_serial_port.sv drives the link pins
`timescale 1ns/1ns

module adc_power_shutdown_control_test;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cfg;
    logic se;
    logic [2:0] ch;
    logic uni;
    logic msb;
    logic [4:0] bits;
  } row_t;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sclk, cs_n, din;
  logic power_down, converter_on, convert_busy, dummy_conv;
  logic single_ended, unipolar, msb_first;
  logic [2:0] channel;
  logic [4:0] word_bits;
  int fails = 0;
  int checks_done = 0;
  int n;
  row_t rows [4] = '{
    '{8'h56, 1'b0, 3'h5, 1'b0, 1'b1, adc_shutdown_pkg::WORD_BITS_12},
    '{8'hff, 1'b1, 3'h7, 1'b1, 1'b1, adc_shutdown_pkg::WORD_BITS_16},
    '{8'hb0, 1'b1, 3'h3, 1'b0, 1'b0, adc_shutdown_pkg::WORD_BITS_8},
    '{8'hef, 1'b1, 3'h6, 1'b1, 1'b1, adc_shutdown_pkg::WORD_BITS_16}};

  // system clock, 10 ns period
  always #5 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  host_serial_port u_host_serial_port (
    .o_sclk(sclk),
    .o_cs_n(cs_n),
    .o_din(din)
  );

  adc_power_shutdown_control u_adc_power_shutdown_control (
    .i_sys_clk(sys_clk),
    .i_reset_n(reset_n),
    .i_sclk(sclk),
    .i_cs_n(cs_n),
    .i_din(din),
    .o_power_down(power_down),
    .o_converter_on(converter_on),
    .o_convert_busy(convert_busy),
    .o_dummy_conv(dummy_conv),
    .o_single_ended(single_ended),
    .o_channel(channel),
    .o_unipolar(unipolar),
    .o_msb_first(msb_first),
    .o_word_bits(word_bits)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // single place where the run ends
  task automatic wrap_up();
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  function automatic logic pick(input int sel);
    return (sel == 0) ? convert_busy : dummy_conv;
  endfunction

  // bounded wait for a level, then its length in system cycles
  task automatic measure(input int sel, output int len);
    int k;
    k = 0;
    len = 0;
    while (pick(sel) !== 1'b1 && k < 400) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    if (k == 400) begin
      fails++;
      wrap_up();
    end else begin
      while (pick(sel) === 1'b1 && len < 50) begin
        @(posedge sys_clk);
        #1;
        len++;
      end
    end
  endtask

  task automatic check_cfg(input row_t r);
    check("single_ended", {7'h0, r.se}, {7'h0, single_ended});
    check("channel", {5'h0, r.ch}, {5'h0, channel});
    check("unipolar", {7'h0, r.uni}, {7'h0, unipolar});
    check("msb_first", {7'h0, r.msb}, {7'h0, msb_first});
    check("word_bits", {3'h0, r.bits}, {3'h0, word_bits});
  endtask

  task automatic check_power(input logic down);
    check("power_down", {7'h0, down}, {7'h0, power_down});
    check("converter_on", {7'h0, ~down}, {7'h0, converter_on});
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    // defaults equal an all-high config word
    check_power(1'b0);
    check_cfg('{8'hff, 1'b1, 3'h7, 1'b1, 1'b1, adc_shutdown_pkg::WORD_BITS_16});
    // ordinary config words, one frame each
    foreach (rows[i]) begin
      u_host_serial_port.send_frame(rows[i].cfg, 16, 6, 1'b0);
      repeat (5) @(posedge sys_clk);
      #1;
      check_cfg(rows[i]);
    end
    // second frame with select held low restarts the request
    u_host_serial_port.send_frame(8'hb0, 16, 6, 1'b1);
    u_host_serial_port.send_frame(8'h56, 16, 6, 1'b0);
    repeat (5) @(posedge sys_clk);
    #1;
    check("restart word_bits", 8'h0c, {3'h0, word_bits});
    // shutdown with only ten clocks: dummy conversion then sleep
    fork
      u_host_serial_port.send_frame(8'h3d, 10, 6, 1'b0);
      measure(1, n);
    join
    check("dummy cycles", {3'h0, adc_shutdown_pkg::CONV_CYCLES}, 8'(n));
    check_power(1'b1);
    check("shutdown word_bits", 8'h0c, {3'h0, word_bits});
    repeat (20) @(posedge sys_clk);
    #1;
    check_power(1'b1);
    // select falling wakes it and converts at once
    fork
      u_host_serial_port.send_frame(8'hef, 16, 6, 1'b0);
      measure(0, n);
    join
    check("busy cycles", {3'h0, adc_shutdown_pkg::CONV_CYCLES}, 8'(n));
    check_power(1'b0);
    check("wake word_bits", 8'h10, {3'h0, word_bits});
    // select held low, clocks pause past the dummy run, the rest then wake it
    fork
      u_host_serial_port.send_frame(8'h3d, 10, 6, 1'b1);
      measure(1, n);
    join
    check("held dummy cycles", {3'h0, adc_shutdown_pkg::CONV_CYCLES}, 8'(n));
    check_power(1'b1);
    u_host_serial_port.send_frame(8'h3d, 6, 6, 1'b0);
    repeat (5) @(posedge sys_clk);
    #1;
    check_power(1'b0);
    // mid-run reset brings back the all-high defaults
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check_power(1'b0);
    check_cfg(rows[1]);
    wrap_up();
  end
endmodule // adc_power_shutdown_control_test
